// [verilog/ssf_pkg.sv]
package ssf_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] STATUS_ADDR = 32'h8000_0140;
    localparam logic [31:0] HALT_ADDR = 32'h8000_0180;
    localparam logic [31:0] STANDBY_ADDR = 32'h8000_0184;
    localparam logic [31:0] FLAG_CLEAR_ADDR = 32'h8000_0188;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h8000_018C;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h8000_0190;

    // ------------------------------------------------------------------
    // Status word field positions
    // ------------------------------------------------------------------
    localparam int MEDIA_BIT = 0;
    localparam int EXT_POWER_BIT = 1;
    localparam int WAKE_LIVE_BIT = 2;
    localparam int WAKE_FLAG_BIT = 3;
    localparam int DISPLAY_LSB = 4;
    localparam int CTS_BIT = 8;
    localparam int DSR_BIT = 9;
    localparam int DCD_BIT = 10;
    localparam int TX_BUSY_BIT = 11;
    localparam int BATTERY_BIT = 12;
    localparam int RESET_BTN_BIT = 13;
    localparam int POWER_FAIL_BIT = 14;
    localparam int COLD_START_BIT = 15;
    localparam int PRESCALE_LSB = 16;
    localparam int RX_EMPTY_BIT = 22;

    // ------------------------------------------------------------------
    // Interrupt status bit positions
    // ------------------------------------------------------------------
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_BATTERY = 1;
    localparam int IRQ_RESET_BTN = 2;
    localparam int IRQ_POWER_FAIL = 3;
    localparam int IRQ_BITS = 4;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic COLD_START_RESET = 1'b1;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam int PRESCALE_DIVIDE = 64;
    localparam int PRESCALE_WIDTH = 6;

    // Standby state machine, one-hot.
    typedef enum logic [1:0] {
        SSF_RUN = 2'b01,
        SSF_STANDBY = 2'b10
    } ssf_power_e;

endpackage : ssf_pkg

// [verilog/ssf_status.sv]
// Function
// - Bit 0 is inverted live media-change pin.
// - Bit 1 is inverted external power pin.
// - Bit 2 shows live wakeup level.
// - Bit 3 sets on wakeup from standby.
// - Bit 3 cleared by reset, halt, standby.
// - Bits 4-7 hold display lines before enable.
// - Bits 8-10 show CTS, DSR, DCD.
// - Bit 11 shows transmitter busy through stop bits.
// - Bit 12 latches battery pin rising edge.
// - Bit 13 latches reset button press.
// - Bit 14 latches power-fail reset.
// - Bit 15 set by power-on reset.
// - Bits 16-21 expose 64 Hz prescaler count.
// - Bit 22 is receive empty, FIFO dependent.
// - Status word is 32-bit read only.
// - Status word sits at its fixed address.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/10ps
module ssf_status #(
    parameter int PRESCALE_DIVIDE = ssf_pkg::PRESCALE_DIVIDE
) (
    // Clock and power-on reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Register port.
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // Board status pins.
    input wire logic sys_reset_in,
    input wire logic media_change_pin_n_in,
    input wire logic external_power_pin_n_in,
    input wire logic wakeup_in,
    input wire logic battery_change_pin_n_in,
    input wire logic user_reset_pin_n_in,
    input wire logic power_fail_pin_n_in,
    // Display identity lines.
    input wire logic [3:0] display_data_in,
    input wire logic display_controller_enable_in,
    // Serial port status.
    input wire logic cts_in,
    input wire logic dsr_in,
    input wire logic dcd_in,
    input wire logic serial_tx_busy_in,
    input wire logic serial_fifo_enable_in,
    input wire logic rx_holding_empty_in,
    input wire logic rx_fifo_empty_in,
    // Real-time clock tick.
    input wire logic tick_64hz_in,
    // Outputs.
    output logic second_tick_out,
    output logic standby_out,
    output logic halt_req_out,
    output logic irq_out
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (PRESCALE_DIVIDE < 2 || PRESCALE_DIVIDE > 64) begin : g_bad_div
        $error("Prescale divide must lie between 2 and 64.");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic wr_halt;
    logic wr_standby;
    logic wr_clear;
    logic wr_irq_stat;
    logic wr_irq_mask;
    // Writes to the status word itself decode to nothing.
    assign wr_halt = wr_in && addr_in == ssf_pkg::HALT_ADDR;
    assign wr_standby = wr_in && addr_in == ssf_pkg::STANDBY_ADDR;
    assign wr_clear = wr_in && addr_in == ssf_pkg::FLAG_CLEAR_ADDR;
    assign wr_irq_stat = wr_in && addr_in == ssf_pkg::IRQ_STATUS_ADDR;
    assign wr_irq_mask = wr_in && addr_in == ssf_pkg::IRQ_MASK_ADDR;

    // ------------------------------------------------------------------
    // Edge detection on board pins
    // ------------------------------------------------------------------
    logic wakeup_prev_q;
    logic battery_prev_q;
    logic wake_rise;
    logic battery_rise;
    logic reset_press;
    logic power_fail_hit;
    // Previous pin levels, reset to the idle level so no false edge shows.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wakeup_prev_q <= 1'b1;
            battery_prev_q <= 1'b1;
        end else begin
            wakeup_prev_q <= wakeup_in;
            battery_prev_q <= battery_change_pin_n_in;
        end
    end
    // Event conditions.
    assign wake_rise = wakeup_in && !wakeup_prev_q;
    assign battery_rise = battery_change_pin_n_in && !battery_prev_q;
    assign reset_press = !user_reset_pin_n_in;
    assign power_fail_hit = !power_fail_pin_n_in;

    // ------------------------------------------------------------------
    // Standby state machine
    // ------------------------------------------------------------------
    ssf_pkg::ssf_power_e power_q;
    logic wake_event;
    assign wake_event = power_q == ssf_pkg::SSF_STANDBY && wake_rise;
    // Standby is entered by a write, left by a wakeup rising edge or a system reset.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            power_q <= ssf_pkg::SSF_RUN;
        end else begin
            case (power_q)
                ssf_pkg::SSF_RUN: begin
                    if (wr_standby) begin
                        power_q <= ssf_pkg::SSF_STANDBY;
                    end
                end
                ssf_pkg::SSF_STANDBY: begin
                    if (wake_rise || sys_reset_in) begin
                        power_q <= ssf_pkg::SSF_RUN;
                    end
                end
                default: begin
                    power_q <= ssf_pkg::SSF_RUN;
                end
            endcase
        end
    end
    assign standby_out = power_q == ssf_pkg::SSF_STANDBY;
    assign halt_req_out = wr_halt;

    // ------------------------------------------------------------------
    // Latched flags; a set in the clearing cycle wins
    // ------------------------------------------------------------------
    logic wake_flag_q;
    logic battery_flag_q;
    logic reset_btn_flag_q;
    logic power_fail_flag_q;
    logic cold_start_flag_q;
    // Wakeup flag, cleared by system reset or halt and standby writes.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wake_flag_q <= 1'b0;
        end else if (wake_event) begin
            wake_flag_q <= 1'b1;
        end else if (sys_reset_in || wr_halt || wr_standby) begin
            wake_flag_q <= 1'b0;
        end
    end
    // Battery, button, power-fail and cold-start flags.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            battery_flag_q <= 1'b0;
            reset_btn_flag_q <= 1'b0;
            power_fail_flag_q <= 1'b0;
            cold_start_flag_q <= ssf_pkg::COLD_START_RESET;
        end else begin
            battery_flag_q <= battery_rise
                || (battery_flag_q && !wr_clear);
            reset_btn_flag_q <= reset_press
                || (reset_btn_flag_q && !wr_clear);
            power_fail_flag_q <= power_fail_hit
                || (power_fail_flag_q && !wr_clear);
            cold_start_flag_q <= cold_start_flag_q && !wr_clear;
        end
    end

    // ------------------------------------------------------------------
    // Display identity latch
    // ------------------------------------------------------------------
    logic [3:0] display_id_q;
    // Follows the lines while disabled, freezes once enabled.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            display_id_q <= 4'h0;
        end else if (!display_controller_enable_in) begin
            display_id_q <= display_data_in;
        end
    end

    // ------------------------------------------------------------------
    // Real-time clock prescaler
    // ------------------------------------------------------------------
    localparam logic [5:0] PRESCALE_LAST = 6'(PRESCALE_DIVIDE - 1);
    logic [5:0] prescale_q;
    // Counts 64 Hz ticks since the last one-second increment.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            prescale_q <= 6'h00;
        end else if (tick_64hz_in) begin
            if (prescale_q == PRESCALE_LAST) begin
                prescale_q <= 6'h00;
            end else begin
                prescale_q <= prescale_q + 6'h01;
            end
        end
    end
    assign second_tick_out = tick_64hz_in && prescale_q == PRESCALE_LAST;

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [3:0] irq_set;
    assign irq_set = {power_fail_hit, reset_press, battery_rise, wake_event};
    // Sticky bits, write one to clear, set wins.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= irq_set
                | (irq_stat_q & ~(wr_irq_stat ? wdata_in[3:0] : 4'h0));
        end
    end
    // Mask register.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_mask_q <= ssf_pkg::IRQ_MASK_RESET;
        end else if (wr_irq_mask) begin
            irq_mask_q <= wdata_in[3:0];
        end
    end
    assign irq_out = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------------
    // Status word and read port
    // ------------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] rdata_d;
    // Live levels are sampled in the read cycle.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ssf_pkg::MEDIA_BIT] = !media_change_pin_n_in;
        status_word[ssf_pkg::EXT_POWER_BIT] =
            !external_power_pin_n_in;
        status_word[ssf_pkg::WAKE_LIVE_BIT] = wakeup_in;
        status_word[ssf_pkg::WAKE_FLAG_BIT] = wake_flag_q;
        status_word[ssf_pkg::DISPLAY_LSB +: 4] = display_id_q;
        status_word[ssf_pkg::CTS_BIT] = cts_in;
        status_word[ssf_pkg::DSR_BIT] = dsr_in;
        status_word[ssf_pkg::DCD_BIT] = dcd_in;
        status_word[ssf_pkg::TX_BUSY_BIT] = serial_tx_busy_in;
        status_word[ssf_pkg::BATTERY_BIT] = battery_flag_q;
        status_word[ssf_pkg::RESET_BTN_BIT] = reset_btn_flag_q;
        status_word[ssf_pkg::POWER_FAIL_BIT] = power_fail_flag_q;
        status_word[ssf_pkg::COLD_START_BIT] = cold_start_flag_q;
        status_word[ssf_pkg::PRESCALE_LSB +: 6] = prescale_q;
        status_word[ssf_pkg::RX_EMPTY_BIT] = serial_fifo_enable_in
            ? rx_fifo_empty_in : rx_holding_empty_in;
    end
    // Read mux; unmapped addresses read zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_in) begin
            case (addr_in)
                ssf_pkg::STATUS_ADDR: rdata_d = status_word;
                ssf_pkg::IRQ_STATUS_ADDR: rdata_d = {28'h000_0000, irq_stat_q};
                ssf_pkg::IRQ_MASK_ADDR: rdata_d = {28'h000_0000, irq_mask_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end
    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic rd_stat;
    assign rd_stat = rd_in && addr_in == ssf_pkg::STATUS_ADDR;
    a_media_inverted: assert property (
        rd_stat |=> rdata_out[0] == !$past(media_change_pin_n_in))
        else $error("Media bit is not the inverted pin.");
    a_power_inverted: assert property (
        rd_stat |=> rdata_out[1] == !$past(external_power_pin_n_in))
        else $error("External power bit is wrong.");
    a_wake_live: assert property (
        rd_stat |=> rdata_out[2] == $past(wakeup_in))
        else $error("Wakeup live bit is wrong.");
    a_wake_sets: assert property (
        standby_out && wakeup_in && !wakeup_prev_q
        |=> wake_flag_q && !standby_out)
        else $error("Wakeup flag did not set.");
    a_wake_clears: assert property (
        (sys_reset_in || wr_halt || wr_standby) && !wake_event
        |=> !wake_flag_q)
        else $error("Wakeup flag did not clear.");
    a_display_frozen: assert property (
        display_controller_enable_in ##1 display_controller_enable_in
        |-> $stable(display_id_q))
        else $error("Display nibble moved while enabled.");
    a_modem_bits: assert property (
        rd_stat |=> rdata_out[10:8] == $past({dcd_in, dsr_in, cts_in}))
        else $error("Modem bits are wrong.");
    a_battery_latch: assert property (
        battery_rise |=> battery_flag_q [*2] or
        (battery_flag_q ##1 $past(wr_clear)))
        else $error("Battery flag did not hold.");
    a_flags_clear: assert property (
        wr_clear && !battery_rise && !reset_press && !power_fail_hit
        |=> !battery_flag_q && !reset_btn_flag_q && !power_fail_flag_q)
        else $error("Clear write left a flag set.");
    a_cold_clear: assert property (
        wr_clear |=> !cold_start_flag_q)
        else $error("Cold start flag stayed set.");
    a_prescale_wrap: assert property (
        tick_64hz_in && prescale_q == PRESCALE_LAST
        |-> second_tick_out ##1 prescale_q == 6'h00)
        else $error("Prescaler did not wrap.");
    a_rx_empty_sel: assert property (
        rd_stat && serial_fifo_enable_in |=> rdata_out[22] ==
        $past(rx_fifo_empty_in))
        else $error("Receive empty bit ignores FIFO mode.");
    a_status_readonly: assert property (
        wr_in && addr_in == ssf_pkg::STATUS_ADDR && !battery_rise
        |=> $stable(battery_flag_q) && $stable(cold_start_flag_q))
        else $error("Status write changed a flag.");
    a_irq_level: assert property (
        |(irq_set & irq_mask_q) && !wr_irq_mask |=> irq_out)
        else $error("Interrupt did not rise.");
    c_wake_from_standby: cover property (wr_standby ##[1:20] wake_event);
    c_clear_after_press: cover property (reset_btn_flag_q ##[1:10] wr_clear);
    c_prescale_wrap: cover property (second_tick_out);

endmodule : ssf_status

// [testbench/ssf_board.sv]
`timescale 1ns/10ps
module ssf_board #(
    parameter int TICK_GAP = 5,
    parameter int FRAME_CYCLES = 10
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Controls from the bench.
    input wire logic tick_run_in,
    input wire logic tx_start_in,
    // Pins towards the block.
    output logic tick_64hz_out,
    output logic serial_tx_busy_out
);
    logic [7:0] gap_q;
    logic [7:0] frame_q;

    // Tick source: a one-cycle pulse every TICK_GAP cycles while running.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            gap_q <= 8'h00;
            tick_64hz_out <= 1'b0;
        end else if (tick_run_in && gap_q == 8'(TICK_GAP - 1)) begin
            gap_q <= 8'h00;
            tick_64hz_out <= 1'b1;
        end else begin
            gap_q <= tick_run_in ? gap_q + 8'h01 : 8'h00;
            tick_64hz_out <= 1'b0;
        end
    end

    // Transmitter stays busy from start until the last stop bit is out.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            frame_q <= 8'h00;
        end else if (tx_start_in) begin
            frame_q <= 8'(FRAME_CYCLES);
        end else if (frame_q != 8'h00) begin
            frame_q <= frame_q - 8'h01;
        end
    end
    assign serial_tx_busy_out = (frame_q != 8'h00);
endmodule : ssf_board

// [testbench/system_status_flags_bench.sv]
`timescale 1ns/10ps
module system_status_flags_bench;
    localparam int DIVIDE = 4;
    logic clock_in, rst_in, wr_in, rd_in, sys_reset_in;
    logic [31:0] addr_in, wdata_in, rdata_out, got, snap;
    logic media_n, ext_n, wakeup, bat_n, ureset_n, pf_n, disp_en;
    logic [3:0] disp_data, exp_nib;
    logic cts, dsr, dcd, tx_busy, fifo_en, hold_empty, fifo_empty, tick;
    logic tick_run, tx_start, second_tick, standby, halt_req, irq;
    logic exp_wake, exp_bat, exp_rst, exp_pf, exp_cold;
    logic [5:0] pre_q;
    logic [8:0] pats [4];
    int num_errors, comparisons;

    ssf_status #(.PRESCALE_DIVIDE(DIVIDE)) u_dut (
        .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .sys_reset_in(sys_reset_in),
        .media_change_pin_n_in(media_n), .external_power_pin_n_in(ext_n),
        .wakeup_in(wakeup), .battery_change_pin_n_in(bat_n),
        .user_reset_pin_n_in(ureset_n), .power_fail_pin_n_in(pf_n),
        .display_data_in(disp_data), .display_controller_enable_in(disp_en),
        .cts_in(cts), .dsr_in(dsr), .dcd_in(dcd),
        .serial_tx_busy_in(tx_busy), .serial_fifo_enable_in(fifo_en),
        .rx_holding_empty_in(hold_empty), .rx_fifo_empty_in(fifo_empty),
        .tick_64hz_in(tick), .second_tick_out(second_tick),
        .standby_out(standby), .halt_req_out(halt_req), .irq_out(irq));

    ssf_board u_board (
        .clock_in(clock_in), .rst_in(rst_in), .tick_run_in(tick_run),
        .tx_start_in(tx_start), .tick_64hz_out(tick),
        .serial_tx_busy_out(tx_busy));

    // Clock at 25 MHz.
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    // Compares one value and counts a mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the verdict and stops.
    task automatic complete_run();
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // Status word expected from the pins and the tracked flags.
    function automatic logic [31:0] status_exp();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[0] = ~media_n;
        w[1] = ~ext_n;
        w[2] = wakeup;
        w[3] = exp_wake;
        w[7:4] = exp_nib;
        w[10:8] = {dcd, dsr, cts};
        w[11] = tx_busy;
        w[15:12] = {exp_cold, exp_pf, exp_rst, exp_bat};
        w[21:16] = pre_q;
        w[22] = fifo_en ? fifo_empty : hold_empty;
        return w;
    endfunction : status_exp

    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
    endtask : step

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr

    // Read; the expected status is captured at the edge that takes it.
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        snap = status_exp();
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd

    task automatic chk_status();
        rd(ssf_pkg::STATUS_ADDR, got);
        check(got, snap);
    endtask : chk_status

    // Raises wakeup from low; the block must leave standby.
    task automatic wake();
        @(posedge clock_in);
        wakeup <= 1'b0;
        @(posedge clock_in);
        wakeup <= 1'b1;
        step(2);
        exp_wake = 1'b1;
        #1 check(standby, 1'b0);
    endtask : wake

    // Prescaler model and second pulse check on every tick.
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pre_q <= 6'h00;
        end else if (tick) begin
            check(second_tick, pre_q == 6'(DIVIDE - 1));
            pre_q <= (pre_q == 6'(DIVIDE - 1)) ? 6'h00 : pre_q + 6'h01;
        end
    end

    // Watchdog against a hang.
    initial begin
        #(40 * 4000);
        num_errors++;
        complete_run();
    end

    initial begin
        num_errors = 0;
        comparisons = 0;
        pats = '{9'h155, 9'h0aa, 9'h1ff, 9'h000};
        {rst_in, wr_in, rd_in, sys_reset_in} = 4'h8;
        addr_in = 32'h0000_0000;
        wdata_in = 32'h0000_0000;
        {media_n, ext_n, wakeup, bat_n, ureset_n, pf_n} = 6'h3b;
        {disp_en, disp_data} = 5'h0a;
        {cts, dsr, dcd, fifo_en, hold_empty, fifo_empty} = 6'h02;
        {tick_run, tx_start} = 2'h0;
        {exp_wake, exp_bat, exp_rst, exp_pf, exp_cold} = 5'h01;
        exp_nib = 4'ha;
        step(3);
        rst_in <= 1'b0;
        chk_status();
        wr(ssf_pkg::STATUS_ADDR, 32'hffff_ffff);
        chk_status();
        rd(32'h8000_0200, got);
        check(got, 32'h0000_0000);
        // Live pins, both receive-empty sources.
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_in);
            {media_n, ext_n, wakeup, cts, dsr, dcd} <= pats[i][8:3];
            {fifo_en, hold_empty, fifo_empty} <= pats[i][2:0];
            chk_status();
        end
        // Transmitter busy during and after a character.
        @(posedge clock_in);
        tx_start <= 1'b1;
        @(posedge clock_in);
        tx_start <= 1'b0;
        chk_status();
        check(got[11], 1'b1);
        step(10);
        chk_status();
        check(got[11], 1'b0);
        // Display nibble frozen while enabled, tracking while disabled.
        @(posedge clock_in);
        {disp_en, disp_data} <= 5'h15;
        step(2);
        chk_status();
        @(posedge clock_in);
        disp_en <= 1'b0;
        exp_nib = 4'h5;
        step(2);
        chk_status();
        @(posedge clock_in);
        disp_data <= 4'h3;
        @(posedge clock_in);
        {disp_en, disp_data} <= 5'h1c;
        exp_nib = 4'h3;
        step(2);
        chk_status();
        // Battery edge, reset button and power fail events.
        @(posedge clock_in);
        bat_n <= 1'b0;
        @(posedge clock_in);
        {bat_n, ureset_n} <= 2'h2;
        @(posedge clock_in);
        {ureset_n, pf_n} <= 2'h2;
        @(posedge clock_in);
        pf_n <= 1'b1;
        {exp_bat, exp_rst, exp_pf} = 3'h7;
        chk_status();
        rd(ssf_pkg::IRQ_STATUS_ADDR, got);
        check(got, 32'h0000_000e);
        check(irq, 1'b0);
        wr(ssf_pkg::IRQ_MASK_ADDR, 32'h0000_0004);
        #1 check(irq, 1'b1);
        rd(ssf_pkg::IRQ_MASK_ADDR, got);
        check(got, 32'h0000_0004);
        wr(ssf_pkg::IRQ_STATUS_ADDR, 32'h0000_0004);
        #1 check(irq, 1'b0);
        wr(ssf_pkg::FLAG_CLEAR_ADDR, 32'h0000_0000);
        {exp_bat, exp_rst, exp_pf, exp_cold} = 4'h0;
        chk_status();
        // Standby, wakeup and the three ways to clear the wake flag.
        wr(ssf_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
        #1 check(irq, 1'b0);
        wr(ssf_pkg::STANDBY_ADDR, 32'h1234_5678);
        #1 check(standby, 1'b1);
        wake();
        check(irq, 1'b1);
        chk_status();
        rd(ssf_pkg::IRQ_STATUS_ADDR, got);
        check(got, 32'h0000_000b);
        wr(ssf_pkg::STANDBY_ADDR, 32'h0000_0000);
        exp_wake = 1'b0;
        chk_status();
        wake();
        @(posedge clock_in);
        addr_in <= ssf_pkg::HALT_ADDR;
        wr_in <= 1'b1;
        #1 check(halt_req, 1'b1);
        @(posedge clock_in);
        wr_in <= 1'b0;
        exp_wake = 1'b0;
        chk_status();
        wr(ssf_pkg::STANDBY_ADDR, 32'h0000_0000);
        wake();
        @(posedge clock_in);
        sys_reset_in <= 1'b1;
        @(posedge clock_in);
        sys_reset_in <= 1'b0;
        exp_wake = 1'b0;
        chk_status();
        // Prescaler count under running ticks.
        @(posedge clock_in);
        tick_run <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            step(3);
            chk_status();
        end
        complete_run();
    end
endmodule : system_status_flags_bench
